// ==== inc/plc_pkg.sv ====
// Package of constants and types for the PID loop status and error block.
// Functional notes
// RULE_01 - Scaling flag clears whenever setpoint scaling min and max are specified.
// RULE_02 - Set loop-too-fast flag when computation cannot keep up with update interval.
// RULE_03 - Select bit 1 takes rate from error; 0 takes it from process variable.
// RULE_04 - Set upper alarm when calculated output exceeds upper output limit.
// RULE_05 - Set lower alarm when calculated output is below lower output limit.
// RULE_06 - Set setpoint range flag when setpoint lies outside scaled min or max.
// RULE_07 - Set process range flag when raw process variable exceeds 16383 or negative.
// RULE_08 - Done flag high one scan after a computation; cleared otherwise in timed mode.
// RULE_09 - Active flag follows the instruction enable condition.
// RULE_10 - Integral accumulator is a 32-bit signed sum of gain-scaled error; code divides each new sum by reset time.
// RULE_11 - Keep read-only 32-bit signed word tracking process variable change.
// RULE_12 - On any fault post code 0036 and a detail byte in word two upper byte.
// RULE_13 - Detail 11H when update interval is zero or above 1024.
// RULE_14 - Detail 12H, 13H, 14H for negative gain, reset time, rate time.
// RULE_15 - Detail 15H when feedforward bias lies outside -16383 to +16383.
// RULE_16 - Detail 23H when scaled setpoint minimum exceeds scaled maximum.
// RULE_17 - Detail 31H for setpoint out of range; later scans keep last valid setpoint.
// RULE_18 - Detail 41H for negative deadband or deadband above span or 16383.
// RULE_19 - Detail 51H when output high limit is below 0 or above 100.
// RULE_20 - Detail 52H when output low limit is below 0 or above 100.
// RULE_21 - Detail 53H when output low limit exceeds output high limit.
// RULE_22 - Computed control variable is held within 0 to 16383.
// RULE_23 - With several faults, report only the lowest detail code.
package plc_pkg;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_LUT = 4'h2;
  localparam logic [3:0] ADDR_GAIN = 4'h3;
  localparam logic [3:0] ADDR_RESET_T = 4'h4;
  localparam logic [3:0] ADDR_RATE_T = 4'h5;
  localparam logic [3:0] ADDR_BIAS = 4'h6;
  localparam logic [3:0] ADDR_SMIN = 4'h7;
  localparam logic [3:0] ADDR_SMAX = 4'h8;
  localparam logic [3:0] ADDR_SP = 4'h9;
  localparam logic [3:0] ADDR_DB = 4'hA;
  localparam logic [3:0] ADDR_OHI = 4'hB;
  localparam logic [3:0] ADDR_OLO = 4'hC;
  localparam logic [3:0] ADDR_ISUM = 4'hD;
  localparam logic [3:0] ADDR_DTRK = 4'hE;
  localparam logic [3:0] ADDR_ERR = 4'hF;

  localparam int CTRL_RATE_SEL_BIT = 0;
  localparam int CTRL_TIMED_BIT = 1;

  localparam int ST_SCALE_BIT = 0;
  localparam int ST_TOOFAST_BIT = 1;
  localparam int ST_HIGH_BIT = 2;
  localparam int ST_LOW_BIT = 3;
  localparam int ST_SPR_BIT = 4;
  localparam int ST_PVR_BIT = 5;
  localparam int ST_DONE_BIT = 6;
  localparam int ST_ACTIVE_BIT = 7;

  localparam logic signed [15:0] PV_MAX = 16'sh3FFF;
  localparam logic signed [15:0] BIAS_MIN = -16'sh3FFF;
  localparam logic signed [15:0] LUT_MAX = 16'sh0400;
  localparam logic signed [15:0] PCT_MAX = 16'sh0064;
  localparam logic [15:0] FAULT_CODE = 16'h0036;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] LUT_RESET = 16'h0001;
  localparam logic [15:0] OHI_RESET = 16'h0064;

  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_LUT = 8'h11;
  localparam logic [7:0] ERR_GAIN = 8'h12;
  localparam logic [7:0] ERR_RESET_T = 8'h13;
  localparam logic [7:0] ERR_RATE_T = 8'h14;
  localparam logic [7:0] ERR_BIAS = 8'h15;
  localparam logic [7:0] ERR_SCALE = 8'h23;
  localparam logic [7:0] ERR_SP = 8'h31;
  localparam logic [7:0] ERR_DB = 8'h41;
  localparam logic [7:0] ERR_OHI = 8'h51;
  localparam logic [7:0] ERR_OLO = 8'h52;
  localparam logic [7:0] ERR_ORDER = 8'h53;

  // One loop evaluation request from the scan engine.
  typedef struct packed {
    logic enable;
    logic compute;
    logic overrun;
    logic signed [15:0] pv;
    logic signed [15:0] error;
    logic signed [15:0] cv;
  } plc_scan_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } plc_bus_t;

endpackage : plc_pkg

// ==== design/plc_pid_status.sv ====
// PID loop status, alarm, accumulator and parameter fault logic.
`timescale 1ns/10ps
`default_nettype none

module plc_pid_status (
  input wire logic mclk,
  input wire logic rst_n,
  input wire plc_pkg::plc_bus_t bus,
  output logic [31:0] rdata,
  input wire plc_pkg::plc_scan_t scan,
  input wire logic scan_valid,
  output logic signed [15:0] rate_source,
  output logic signed [15:0] active_setpoint,
  output logic signed [15:0] cv_out,
  output logic [15:0] fault_code,
  output logic [7:0] detail_code
);

  // ***************************************************************
  // Parameter words.
  // ***************************************************************
  logic [15:0] ctrl;
  logic [15:0] lut;
  logic signed [15:0] gain;
  logic signed [15:0] reset_t;
  logic signed [15:0] rate_t;
  logic signed [15:0] bias;
  logic signed [15:0] smin;
  logic signed [15:0] smax;
  logic signed [15:0] sp;
  logic signed [15:0] db;
  logic signed [15:0] ohi;
  logic signed [15:0] olo;
  logic [7:0] st;
  logic signed [31:0] isum;
  logic signed [31:0] dtrk;
  logic signed [15:0] last_pv;
  logic first_done;
  logic [7:0] next_detail;
  logic scaling;
  logic sp_bad;
  logic signed [16:0] span;
  logic signed [15:0] pv_clamped;
  logic signed [16:0] cv_hi_lim;
  logic signed [16:0] cv_lo_lim;
  logic signed [31:0] next_isum;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= plc_pkg::CTRL_RESET;
      lut <= plc_pkg::LUT_RESET;
      gain <= plc_pkg::WORD_RESET;
      reset_t <= plc_pkg::WORD_RESET;
      rate_t <= plc_pkg::WORD_RESET;
      bias <= plc_pkg::WORD_RESET;
      smin <= plc_pkg::WORD_RESET;
      smax <= plc_pkg::WORD_RESET;
      sp <= plc_pkg::WORD_RESET;
      db <= plc_pkg::WORD_RESET;
      ohi <= plc_pkg::OHI_RESET;
      olo <= plc_pkg::WORD_RESET;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        plc_pkg::ADDR_CTRL: ctrl <= bus.wdata[15:0];
        plc_pkg::ADDR_LUT: lut <= bus.wdata[15:0];
        plc_pkg::ADDR_GAIN: gain <= bus.wdata[15:0];
        plc_pkg::ADDR_RESET_T: reset_t <= bus.wdata[15:0];
        plc_pkg::ADDR_RATE_T: rate_t <= bus.wdata[15:0];
        plc_pkg::ADDR_BIAS: bias <= bus.wdata[15:0];
        plc_pkg::ADDR_SMIN: smin <= bus.wdata[15:0];
        plc_pkg::ADDR_SMAX: smax <= bus.wdata[15:0];
        plc_pkg::ADDR_SP: sp <= bus.wdata[15:0];
        plc_pkg::ADDR_DB: db <= bus.wdata[15:0];
        plc_pkg::ADDR_OHI: ohi <= bus.wdata[15:0];
        plc_pkg::ADDR_OLO: olo <= bus.wdata[15:0];
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // Parameter checks, lowest code first.
  // ***************************************************************
  assign scaling = (smin != smax);
  assign span = 17'(smax) - 17'(smin);
  assign sp_bad = scaling ? (sp < smin || sp > smax)
                          : (sp < 0 || sp > plc_pkg::PV_MAX); // see RULE_17

  always_comb
  begin
    next_detail = plc_pkg::ERR_NONE;
    if ($signed(lut) <= 0 || $signed(lut) > plc_pkg::LUT_MAX)
      next_detail = plc_pkg::ERR_LUT; // see RULE_13
    else if (gain < 0)
      next_detail = plc_pkg::ERR_GAIN; // see RULE_14
    else if (reset_t < 0)
      next_detail = plc_pkg::ERR_RESET_T; // see RULE_14
    else if (rate_t < 0)
      next_detail = plc_pkg::ERR_RATE_T; // see RULE_14
    else if (bias < plc_pkg::BIAS_MIN || bias > plc_pkg::PV_MAX)
      next_detail = plc_pkg::ERR_BIAS; // see RULE_15
    else if (smin > smax)
      next_detail = plc_pkg::ERR_SCALE; // see RULE_16
    else if (sp_bad)
      next_detail = plc_pkg::ERR_SP; // see RULE_17
    else if (db < 0 || (scaling ? 17'(db) > span : db > plc_pkg::PV_MAX))
      next_detail = plc_pkg::ERR_DB; // see RULE_18
    else if (ohi < 0 || ohi > plc_pkg::PCT_MAX)
      next_detail = plc_pkg::ERR_OHI; // see RULE_19
    else if (olo < 0 || olo > plc_pkg::PCT_MAX)
      next_detail = plc_pkg::ERR_OLO; // see RULE_20
    else if (olo > ohi)
      next_detail = plc_pkg::ERR_ORDER; // see RULE_21
  end // see RULE_23

  // Fault report latched on each scan evaluation.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      detail_code <= plc_pkg::ERR_NONE;
      fault_code <= plc_pkg::WORD_RESET;
    end
    else if (scan_valid && scan.enable)
    begin
      detail_code <= next_detail; // see RULE_12
      fault_code <= (next_detail != plc_pkg::ERR_NONE) ?
                    plc_pkg::FAULT_CODE : plc_pkg::WORD_RESET; // see RULE_12
    end
  end

  // First scan loads any setpoint; later ones keep the last valid one.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_setpoint <= plc_pkg::WORD_RESET;
      first_done <= 1'b0;
    end
    else if (scan_valid && scan.enable)
    begin
      first_done <= 1'b1;
      if (!first_done || !sp_bad)
        active_setpoint <= sp; // see RULE_17
    end
  end

  // ***************************************************************
  // Status flags.
  // ***************************************************************
  assign pv_clamped = (scan.pv < 0) ? 16'sh0000 :
                      (scan.pv > plc_pkg::PV_MAX) ? plc_pkg::PV_MAX : scan.pv;
  assign cv_hi_lim = 17'((32'(ohi) * 32'(plc_pkg::PV_MAX)) / 32'(plc_pkg::PCT_MAX));
  assign cv_lo_lim = 17'((32'(olo) * 32'(plc_pkg::PV_MAX)) / 32'(plc_pkg::PCT_MAX));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st <= 8'h00;
    else
    begin
      st[plc_pkg::ST_ACTIVE_BIT] <= scan_valid ? scan.enable
                                  : st[plc_pkg::ST_ACTIVE_BIT]; // see RULE_09
      st[plc_pkg::ST_SCALE_BIT] <= !scaling; // see RULE_01
      if (scan_valid && scan.enable)
      begin
        st[plc_pkg::ST_TOOFAST_BIT] <= scan.overrun; // see RULE_02
        st[plc_pkg::ST_HIGH_BIT] <= 17'(scan.cv) > cv_hi_lim; // see RULE_04
        st[plc_pkg::ST_LOW_BIT] <= 17'(scan.cv) < cv_lo_lim; // see RULE_05
        st[plc_pkg::ST_SPR_BIT] <= scaling && (sp < smin || sp > smax); // see RULE_06
        st[plc_pkg::ST_PVR_BIT] <= scan.pv < 0 || scan.pv > plc_pkg::PV_MAX; // see RULE_07
        if (scan.compute || ctrl[plc_pkg::CTRL_TIMED_BIT])
          st[plc_pkg::ST_DONE_BIT] <= scan.compute; // see RULE_08
      end
      else if (bus.wr && bus.addr == plc_pkg::ADDR_STATUS)
      begin
        st[plc_pkg::ST_TOOFAST_BIT] <= bus.wdata[plc_pkg::ST_TOOFAST_BIT];
        st[plc_pkg::ST_HIGH_BIT] <= bus.wdata[plc_pkg::ST_HIGH_BIT];
        st[plc_pkg::ST_LOW_BIT] <= bus.wdata[plc_pkg::ST_LOW_BIT];
        st[plc_pkg::ST_SPR_BIT] <= bus.wdata[plc_pkg::ST_SPR_BIT];
        st[plc_pkg::ST_PVR_BIT] <= bus.wdata[plc_pkg::ST_PVR_BIT];
      end
    end
  end

  // ***************************************************************
  // Rate source, clamped output, accumulators.
  // ***************************************************************
  assign next_isum = isum + (32'(gain) * 32'(scan.error));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rate_source <= plc_pkg::WORD_RESET;
      cv_out <= plc_pkg::WORD_RESET;
      last_pv <= plc_pkg::WORD_RESET;
      dtrk <= 32'sh0000_0000;
    end
    else if (scan_valid && scan.enable && scan.compute)
    begin
      rate_source <= ctrl[plc_pkg::CTRL_RATE_SEL_BIT] ?
                     scan.error : pv_clamped; // see RULE_03
      cv_out <= (scan.cv < 0) ? 16'sh0000 :
                (scan.cv > plc_pkg::PV_MAX) ? plc_pkg::PV_MAX : scan.cv; // see RULE_22
      dtrk <= 32'(pv_clamped) - 32'(last_pv); // see RULE_11
      last_pv <= pv_clamped;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      isum <= 32'sh0000_0000;
    else if (scan_valid && scan.enable && scan.compute && reset_t != 0)
      isum <= next_isum / 32'(reset_t); // see RULE_10
    else if (bus.wr && bus.addr == plc_pkg::ADDR_ISUM)
      isum <= bus.wdata;
  end

  // ***************************************************************
  // Read port, data one cycle after the strobe.
  // ***************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0000_0000;
    else if (bus.rd)
    begin
      case (bus.addr)
        plc_pkg::ADDR_CTRL: rdata <= {16'h0000, ctrl};
        plc_pkg::ADDR_STATUS: rdata <= {24'h00_0000, st};
        plc_pkg::ADDR_LUT: rdata <= {16'h0000, lut};
        plc_pkg::ADDR_GAIN: rdata <= {16'h0000, gain};
        plc_pkg::ADDR_RESET_T: rdata <= {16'h0000, reset_t};
        plc_pkg::ADDR_RATE_T: rdata <= {16'h0000, rate_t};
        plc_pkg::ADDR_BIAS: rdata <= {16'h0000, bias};
        plc_pkg::ADDR_SMIN: rdata <= {16'h0000, smin};
        plc_pkg::ADDR_SMAX: rdata <= {16'h0000, smax};
        plc_pkg::ADDR_SP: rdata <= {16'h0000, sp};
        plc_pkg::ADDR_DB: rdata <= {16'h0000, db};
        plc_pkg::ADDR_OHI: rdata <= {16'h0000, ohi};
        plc_pkg::ADDR_OLO: rdata <= {16'h0000, olo};
        plc_pkg::ADDR_ISUM: rdata <= isum;
        plc_pkg::ADDR_DTRK: rdata <= dtrk;
        plc_pkg::ADDR_ERR: rdata <= {detail_code, 8'h00, fault_code};
        default: rdata <= 32'h0000_0000;
      endcase
    end
    else
      rdata <= 32'h0000_0000;
  end

endmodule : plc_pid_status
`default_nettype wire

// ==== tb/plc_pid_status_properties.sv ====
// Port checker for the PID loop status and fault block.
`timescale 1ns/10ps
`default_nettype none
module plc_pid_status_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire plc_pkg::plc_bus_t bus,
  input wire logic [31:0] rdata,
  input wire plc_pkg::plc_scan_t scan,
  input wire logic scan_valid,
  input wire logic signed [15:0] rate_source,
  input wire logic signed [15:0] active_setpoint,
  input wire logic signed [15:0] cv_out,
  input wire logic [15:0] fault_code,
  input wire logic [7:0] detail_code
);
  // ***************************************************************
  // Relations between scan requests and the registered outputs.
  // ***************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire logic cmp = scan_valid && scan.enable && scan.compute;
  chk_fault_detail: assert property (
    fault_code == ((detail_code != 8'h00) ? plc_pkg::FAULT_CODE : 16'h0000))
    else $error("fault code does not follow detail code");
  chk_cv_high: assert property (
    cmp && scan.cv > plc_pkg::PV_MAX |=> cv_out == plc_pkg::PV_MAX)
    else $error("control output not clamped high");
  chk_cv_low: assert property (
    cmp && scan.cv < 0 |=> cv_out == 16'sh0000)
    else $error("control output not clamped low");
  chk_cv_pass: assert property (
    cmp && scan.cv >= 0 && scan.cv <= plc_pkg::PV_MAX
    |=> cv_out == $past(scan.cv))
    else $error("control output not taken from scan");
  chk_cv_hold: assert property (
    !cmp |=> $stable(cv_out))
    else $error("control output moved without computation");
  chk_rate_hold: assert property (
    !cmp |=> $stable(rate_source))
    else $error("rate source moved without computation");
  chk_read_idle: assert property (
    !bus.rd |=> rdata == 32'h0000_0000)
    else $error("read data outside read answer");
  chk_detail_set: assert property (
    detail_code inside {8'h00, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h23,
      8'h31, 8'h41, 8'h51, 8'h52, 8'h53})
    else $error("detail code not a single known code");
  cover property (cmp ##1 cv_out == plc_pkg::PV_MAX);
  cover property (detail_code == plc_pkg::ERR_SP);
  cover property (bus.rd ##1 rdata != 32'h0000_0000);
endmodule : plc_pid_status_properties
bind plc_pid_status plc_pid_status_properties chk_i (.mclk, .rst_n, .bus,
  .rdata, .scan, .scan_valid, .rate_source, .active_setpoint, .cv_out,
  .fault_code, .detail_code);
`default_nettype wire

// ==== tb/plc_scan_engine.sv ====
// Scan engine model presenting one loop evaluation per request.
`timescale 1ns/10ps
`default_nettype none
module plc_scan_engine (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  input wire plc_pkg::plc_scan_t req,
  output plc_pkg::plc_scan_t scan,
  output logic scan_valid
);
  // ***************************************************************
  // Outside a request the fields show the inverse of the last value.
  // ***************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      scan <= '0;
    else
      scan <= go ? req : ~scan;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      scan_valid <= 1'b0;
    else
      scan_valid <= go;
  end
endmodule : plc_scan_engine
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the PID loop status and fault block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  plc_pkg::plc_bus_t bus = '0;
  plc_pkg::plc_scan_t req = '0;
  plc_pkg::plc_scan_t scan;
  logic scan_valid;
  logic [31:0] rdata;
  logic [31:0] v;
  logic signed [15:0] rate_source, active_setpoint, cv_out;
  logic [15:0] fault_code;
  logic [7:0] detail_code;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  initial forever #4 mclk = ~mclk;
  plc_scan_engine plc_scan_engine_i (.mclk, .rst_n, .go, .req, .scan,
    .scan_valid);
  plc_pid_status plc_pid_status_i (.mclk, .rst_n, .bus, .rdata, .scan,
    .scan_valid, .rate_source, .active_setpoint, .cv_out, .fault_code,
    .detail_code);
  // ***************************************************************
  // Bus, scan and compare tasks.
  // ***************************************************************
  task automatic chk(input string what, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic scan_run(input logic [2:0] f, input logic [15:0] p, e, c);
    @(posedge mclk);
    go <= 1'b1;
    req <= {f, p, e, c};
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : scan_run
  task automatic t_reset;
    rd(4'h0);
    chk("ctrl", 32'h0000_0000, v);
    rd(4'h2);
    chk("lut", 32'h0000_0001, v);
    rd(4'hB);
    chk("out high", 32'h0000_0064, v);
    wr(4'h1, 32'h0000_00FF);
    rd(4'h1);
    chk("status", 32'h0000_003F, v);
    wr(4'h1, 32'h0000_0000);
    wr(4'hE, 32'h0000_0005);
    rd(4'hE);
    chk("deriv track", 32'h0000_0000, v);
    $display("reset test done");
  endtask : t_reset
  task automatic t_errors;
    logic [3:0] a[12] = '{2, 2, 3, 4, 5, 6, 7, 9, 10, 11, 12, 12};
    logic [31:0] d[12] = '{0, 1025, -1, -1, -1, -16384, 5, 16384, -1,
      101, -1, 101};
    logic [7:0] c[12] = '{8'h11, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h23,
      8'h31, 8'h41, 8'h51, 8'h52, 8'h52};
    logic [31:0] r[12] = '{1, 1, 0, 0, 0, 0, 0, 0, 0, 100, 0, 0};
    for (int i = 0; i < 12; i++)
    begin
      wr(a[i], d[i]);
      scan_run(3'b100, 0, 0, 0);
      chk("detail", c[i], detail_code);
      chk("fault", plc_pkg::FAULT_CODE, fault_code);
      wr(a[i], r[i]);
    end
    wr(4'hC, 60);
    wr(4'hB, 50);
    scan_run(3'b100, 0, 0, 0);
    chk("detail", 8'h53, detail_code);
    wr(4'h2, 0);
    wr(4'h3, -1);
    scan_run(3'b100, 0, 0, 0);
    chk("detail", 8'h11, detail_code);
    wr(4'h2, 1);
    wr(4'h3, 0);
    wr(4'hC, 0);
    wr(4'hB, 100);
    scan_run(3'b100, 0, 0, 0);
    chk("fault", 16'h0000, fault_code);
    $display("error test done");
  endtask : t_errors
  task automatic t_flags;
    logic [15:0] p[4] = '{16384, -1, 16383, 0};
    logic [15:0] cv[4] = '{8192, 8191, 1637, 1638};
    for (int i = 0; i < 4; i++)
    begin
      scan_run(3'b100, p[i], 0, 0);
      rd(4'h1);
      chk("pv range", i < 2, v[5]);
    end
    wr(4'hB, 50);
    wr(4'hC, 10);
    for (int i = 0; i < 4; i++)
    begin
      scan_run(3'b110, 0, 0, cv[i]);
      chk("cv out", cv[i], cv_out);
      rd(4'h1);
      chk("upper alarm", i == 0, v[2]);
      chk("lower alarm", i == 2, v[3]);
    end
    scan_run(3'b110, 0, 0, -5);
    chk("cv out", 32'h0000_0000, cv_out);
    scan_run(3'b101, 0, 0, 0);
    rd(4'h1);
    chk("too fast", 1'b1, v[1]);
    chk("active", 1'b1, v[7]);
    scan_run(3'b000, 0, 0, 0);
    rd(4'h1);
    chk("active", 1'b0, v[7]);
    $display("flag test done");
  endtask : t_flags
  task automatic t_compute;
    wr(4'h0, 3);
    scan_run(3'b110, 9, 7, 0);
    rd(4'h1);
    chk("done", 1'b1, v[6]);
    chk("rate", 16'sd7, rate_source);
    rd(4'hE);
    chk("deriv track", 32'h0000_0009, v);
    wr(4'h0, 2);
    scan_run(3'b100, 9, 7, 0);
    rd(4'h1);
    chk("done", 1'b0, v[6]);
    scan_run(3'b110, 9, 7, 0);
    chk("rate", 16'sd9, rate_source);
    wr(4'h7, 10);
    wr(4'h8, 100);
    wr(4'h9, 50);
    scan_run(3'b100, 0, 0, 0);
    rd(4'h1);
    chk("scaling", 1'b0, v[0]);
    chk("setpoint", 16'sd50, active_setpoint);
    wr(4'h9, 200);
    scan_run(3'b100, 0, 0, 0);
    rd(4'h1);
    chk("sp range", 1'b1, v[4]);
    chk("detail", 8'h31, detail_code);
    chk("setpoint", 16'sd50, active_setpoint);
    wr(4'hD, 32'hFFFF_FFFD);
    rd(4'hD);
    chk("isum", 32'hFFFF_FFFD, v);
    wr(4'hD, 0);
    wr(4'h3, 2);
    wr(4'h4, 1);
    scan_run(3'b110, 0, 5, 0);
    scan_run(3'b110, 0, 5, 0);
    scan_run(3'b110, 0, -15, 0);
    rd(4'hD);
    chk("isum", 32'hFFFF_FFF6, v);
    $display("compute test done");
  endtask : t_compute
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_errors();
    t_flags();
    t_compute();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
